// ### bench/dual_uart_host_bus_port_tb.sv
// self-checking bench: host end and device end joined by the bus
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module dual_uart_host_bus_port_tb
  import duart_pkg::*;
;
  logic                            clk;
  logic                            rst_n;
  logic                            cmdValid, cmdReady, cmdWrite, cmdChan, rspValid;
  logic [ADDR_W-1:0]               cmdAddr;
  logic [DATA_W-1:0]               cmdData, rspData, rd;
  logic [CHANNELS-1:0][DATA_W-1:0] txData, rxData;
  logic [CHANNELS-1:0]             txValid, txReady, rxValid, rxReady;
  int                              miscompares, checked, k;

  duart_bus_if busA();
  duart_bus_if busB();  // driven by hand to break host rules

  duart_device_end duart_device_end_inst (.clk(clk), .rst_n(rst_n), .bus(busA), .txData(txData),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady));
  duart_host_end duart_host_end_inst (.clk(clk), .rst_n(rst_n), .bus(busA), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdChan(cmdChan), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .rspValid(rspValid), .rspData(rspData));
  duart_device_end duart_device_end_rogue_inst (.clk(clk), .rst_n(rst_n), .bus(busB), .txData(),
    .txValid(), .txReady(2'h0), .rxData(16'h0000), .rxValid(2'h0), .rxReady());
  duart_bus_asserts duart_bus_asserts_inst (.clk(clk), .rst_n(rst_n), .regAddr(busA.regAddr),
    .readStrobeN(busA.readStrobeN), .writeStrobeN(busA.writeStrobeN), .chanASelectN(busA.chanASelectN),
    .chanBSelectN(busA.chanBSelectN), .hostData(busA.hostData), .hostDataOe(busA.hostDataOe),
    .devDataOe(busA.devDataOe), .chanAIrqOe(busA.chanAIrqOe), .chanBIrqOe(busA.chanBIrqOe),
    .chanAGpOutN(busA.chanAGpOutN), .chanBGpOutN(busA.chanBGpOutN));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one command on the host port; a hang counts as a miscompare
  task automatic hostCycle(input logic wr, input logic ch, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    q = 8'h00;
    while (cmdReady !== 1'b1 && n < 20) begin
      @(posedge clk); #1; n++;
    end
    cmdValid = 1'b1; cmdWrite = wr; cmdChan = ch; cmdAddr = a; cmdData = d;
    @(posedge clk); #1;
    cmdValid = 1'b0;
    // a port that never became ready skips the answer wait and is counted below
    if (!wr && n < 20) begin
      n = 0;
      while (rspValid !== 1'b1 && n < 20) begin
        @(posedge clk); #1; n++;
      end
      q = rspData;
    end
    if (n >= 20) begin
      miscompares++;
      give_verdict();
    end
  endtask

  // valid stays up between back-to-back pushes; the caller lowers it after the burst
  task automatic pushRx(input int ch, input logic [DATA_W-1:0] d);
    rxValid[ch] = 1'b1; rxData[ch] = d;
    @(posedge clk); #1;
  endtask

  task automatic busBStep(input logic rdN, input logic wrN, input logic selAN);
    busB.readStrobeN = rdN; busB.writeStrobeN = wrN; busB.chanASelectN = selAN;
    @(posedge clk); #1;
  endtask

  initial begin
    rst_n = 1'b0; cmdValid = 1'b0; cmdWrite = 1'b0; cmdChan = 1'b0; cmdAddr = 3'h0; cmdData = 8'h00;
    txReady = 2'h0; rxValid = 2'h0; rxData = 16'h0000; miscompares = 0; checked = 0;
    busB.regAddr = OFF_LINE_CTRL; busB.readStrobeN = 1'b1; busB.writeStrobeN = 1'b1;
    busB.chanASelectN = 1'b1; busB.chanBSelectN = 1'b1; busB.hostData = 8'h08; busB.hostDataOe = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    // ***************************************************************
    // reset state of pins
    // ***************************************************************
    `CHK("gpA", 1'b1, busA.chanAGpOutN)
    `CHK("irqOeB", 1'b0, busA.chanBIrqOe)
    `CHK("txAvailA", 1'b0, busA.chanATxAvailN)
    `CHK("rxAvailB", 1'b1, busA.chanBRxAvailN)
    `CHK("txAvailB", 1'b0, busA.chanBTxAvailN)
    // ***************************************************************
    // channel separation and address decode
    // ***************************************************************
    hostCycle(1'b1, 1'b0, OFF_SCRATCH, 8'h3C, rd);
    hostCycle(1'b1, 1'b1, OFF_SCRATCH, 8'hC3, rd);
    hostCycle(1'b0, 1'b0, OFF_SCRATCH, 8'h00, rd); `CHK("scrA", 8'h3C, rd)
    hostCycle(1'b0, 1'b1, OFF_SCRATCH, 8'h00, rd); `CHK("scrB", 8'hC3, rd)
    hostCycle(1'b0, 1'b1, 3'h2, 8'h00, rd); `CHK("unused", 8'h00, rd)
    hostCycle(1'b1, 1'b0, OFF_STATUS, 8'h00, rd); // read-only place, write ignored
    hostCycle(1'b0, 1'b0, OFF_STATUS, 8'h00, rd); `CHK("statA", 8'h60, rd)
    // ***************************************************************
    // irq output enable and paired gp output
    // ***************************************************************
    hostCycle(1'b1, 1'b0, OFF_LINE_CTRL, 8'h08, rd);
    hostCycle(1'b1, 1'b0, OFF_IRQ_EN, 8'h02, rd);
    hostCycle(1'b0, 1'b0, OFF_LINE_CTRL, 8'h00, rd); `CHK("lcA", 8'h08, rd)
    `CHK("irqOeA", 1'b1, busA.chanAIrqOe)
    `CHK("gpA", 1'b0, busA.chanAGpOutN)
    `CHK("irqA", 1'b1, busA.chanAIrq)
    `CHK("gpB", 1'b1, busA.chanBGpOutN)
    `CHK("irqB", 1'b0, busA.chanBIrq)
    hostCycle(1'b1, 1'b0, OFF_LINE_CTRL, 8'h00, rd);
    hostCycle(1'b0, 1'b0, OFF_SCRATCH, 8'h00, rd);
    `CHK("irqOeA", 1'b0, busA.chanAIrqOe)
    `CHK("gpA", 1'b1, busA.chanAGpOutN)
    // ***************************************************************
    // receive path on channel b, read in order then empty
    // ***************************************************************
    for (k = 0; k < 3; k++) pushRx(1, 8'hA0 + 8'(k));
    rxValid = 2'h0;
    `CHK("rxRoomB", 1'b1, rxReady[1])
    `CHK("rxAvailB", 1'b0, busA.chanBRxAvailN)
    `CHK("rxAvailA", 1'b1, busA.chanARxAvailN)
    for (k = 0; k < 3; k++) begin
      hostCycle(1'b0, 1'b1, OFF_DATA, 8'h00, rd); `CHK("rxB", 8'hA0 + 8'(k), rd)
    end
    hostCycle(1'b0, 1'b1, OFF_DATA, 8'h00, rd); `CHK("rxEmpty", 8'h00, rd)
    `CHK("rxAvailB", 1'b1, busA.chanBRxAvailN)
    // ***************************************************************
    // transmit fifo on channel a filled past full, then drained
    // ***************************************************************
    for (k = 0; k < FIFO_DEPTH + 1; k++) hostCycle(1'b1, 1'b0, OFF_DATA, 8'(k), rd);
    hostCycle(1'b0, 1'b0, OFF_STATUS, 8'h00, rd); `CHK("statFull", 8'h00, rd)
    `CHK("txAvailA", 1'b1, busA.chanATxAvailN)
    `CHK("txValidB", 1'b0, txValid[1])
    txReady[0] = 1'b1;
    k = 0;
    repeat (FIFO_DEPTH + 8) begin
      if (txValid[0] === 1'b1) begin
        `CHK("txA", 8'(k), txData[0])
        k++;
      end
      @(posedge clk); #1;
    end
    `CHK("txCount", FIFO_DEPTH, k)
    `CHK("txAvailA", 1'b0, busA.chanATxAvailN)
    // ***************************************************************
    // strobes with no select on the second bus are ignored
    // ***************************************************************
    repeat (4) begin
      busBStep(1'b0, 1'b1, 1'b1); `CHK("oeNoSel", 1'b0, busB.devDataOe)
    end
    busBStep(1'b1, 1'b1, 1'b1);
    repeat (4) busBStep(1'b1, 1'b0, 1'b1);
    busBStep(1'b1, 1'b1, 1'b1);
    busB.hostDataOe = 1'b0;
    busBStep(1'b1, 1'b1, 1'b0);
    busBStep(1'b0, 1'b1, 1'b0);
    busBStep(1'b0, 1'b1, 1'b0); `CHK("oeSel", 1'b1, busB.devDataOe)
    `CHK("lcNoSel", 8'h00, busB.busLevel)
    `CHK("irqOeNoSel", 1'b0, busB.chanAIrqOe)
    busBStep(1'b1, 1'b1, 1'b0);
    busBStep(1'b1, 1'b1, 1'b1);
    give_verdict();
  end
endmodule

// ### bench/duart_bus_asserts.sv
// concurrent checks on the host bus between the two ends
`timescale 1ns/100ps
module duart_bus_asserts
  import duart_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              readStrobeN,
  input wire logic              writeStrobeN,
  input wire logic              chanASelectN,
  input wire logic              chanBSelectN,
  input wire logic [DATA_W-1:0] hostData,
  input wire logic              hostDataOe,
  input wire logic              devDataOe,
  input wire logic              chanAIrqOe,
  input wire logic              chanBIrqOe,
  input wire logic              chanAGpOutN,
  input wire logic              chanBGpOutN
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ***************************************************************
  // strobe events
  // ***************************************************************
  sequence readFall;
    $fell(readStrobeN) && !(chanASelectN && chanBSelectN);
  endsequence
  sequence writeFall;
    $fell(writeStrobeN) && !(chanASelectN && chanBSelectN);
  endsequence

  // ***************************************************************
  // checks
  // ***************************************************************
  read_oe_rise_a: assert property (readFall |=> devDataOe [*3])
    else $error("device did not drive the bus during read");
  read_strobe_len_a: assert property (readFall |-> !readStrobeN [*4] ##1 readStrobeN)
    else $error("read strobe width wrong");
  oe_release_a: assert property ($rose(readStrobeN) |=> !devDataOe)
    else $error("bus not released after read strobe rise");
  idle_release_a: assert property (chanASelectN && chanBSelectN |-> !devDataOe)
    else $error("bus driven with no channel selected");
  write_no_drive_a: assert property (!writeStrobeN |-> !devDataOe)
    else $error("device drove bus during write");
  write_drive_len_a: assert property (writeFall |-> hostDataOe [*5])
    else $error("host data not held for write");
  write_hold_a: assert property ($rose(writeStrobeN) |-> hostDataOe && $stable(hostData) && $stable(regAddr))
    else $error("write data or address moved at strobe rise");
  select_setup_a: assert property (($fell(readStrobeN) || $fell(writeStrobeN)) |->
    ($past(chanASelectN) ^ $past(chanBSelectN)))
    else $error("strobe without exactly one select set up");
  gp_pair_a_a: assert property (chanAGpOutN == !chanAIrqOe)
    else $error("channel a gp output not opposite irq enable");
  gp_pair_b_a: assert property (chanBGpOutN == !chanBIrqOe)
    else $error("channel b gp output not opposite irq enable");
endmodule

// ### verilog/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     inValid,
  output wire logic                     inReady,
  input  wire logic [WIDTH-1:0]         inData,
  output wire logic                     outValid,
  input  wire logic                     outReady,
  output wire logic [WIDTH-1:0]         outData
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0]   level;

  wire logic push = inValid && inReady;
  wire logic pop  = outValid && outReady;

  assign inReady  = (level != (PTR_W+1)'(DEPTH));
  assign outValid = (level != '0);
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers wrap by hand so depth need not be a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == PTR_W'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == PTR_W'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      level <= level + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule

// ### verilog/duart_bus_if.sv
// parallel host bus between the host processor and the dual uart
`timescale 1ns/100ps
interface duart_bus_if;
  import duart_pkg::*;

  logic [ADDR_W-1:0] regAddr;
  logic              readStrobeN;
  logic              writeStrobeN;
  logic              chanASelectN;
  logic              chanBSelectN;
  logic [DATA_W-1:0] hostData;
  logic              hostDataOe;
  logic [DATA_W-1:0] devData;
  logic              devDataOe;
  logic [DATA_W-1:0] busLevel;
  logic              chanAIrq;
  logic              chanAIrqOe;
  logic              chanBIrq;
  logic              chanBIrqOe;
  logic              chanAGpOutN;
  logic              chanBGpOutN;
  logic              chanATxAvailN;
  logic              chanARxAvailN;
  logic              chanBTxAvailN;
  logic              chanBRxAvailN;

  // undriven bus floats high through an assumed pull-up
  assign busLevel = devDataOe ? devData : (hostDataOe ? hostData : BUS_IDLE_LEVEL);

  modport device (
    input  regAddr, readStrobeN, writeStrobeN, chanASelectN, chanBSelectN, busLevel,
    output devData, devDataOe, chanAIrq, chanAIrqOe, chanBIrq, chanBIrqOe,
    output chanAGpOutN, chanBGpOutN, chanATxAvailN, chanARxAvailN, chanBTxAvailN, chanBRxAvailN
  );

  modport host (
    output regAddr, readStrobeN, writeStrobeN, chanASelectN, chanBSelectN, hostData, hostDataOe,
    input  busLevel, chanAIrq, chanAIrqOe, chanBIrq, chanBIrqOe,
    input  chanAGpOutN, chanBGpOutN, chanATxAvailN, chanARxAvailN, chanBTxAvailN, chanBRxAvailN
  );
endinterface

// ### verilog/duart_device_end.sv
// device end of the dual uart host bus port with per-channel fifos
`timescale 1ns/100ps

module duart_device_end
  import duart_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  duart_bus_if.device                             bus,
  output wire logic [CHANNELS-1:0][DATA_W-1:0]    txData,
  output wire logic [CHANNELS-1:0]                txValid,
  input  wire logic [CHANNELS-1:0]                txReady,
  input  wire logic [CHANNELS-1:0][DATA_W-1:0]    rxData,
  input  wire logic [CHANNELS-1:0]                rxValid,
  output wire logic [CHANNELS-1:0]                rxReady
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [DATA_W-1:0] statusByte(input logic rxHas, input logic txEmpty,
                                                   input logic txRoom);
    logic [DATA_W-1:0] s;
    s               = '0;
    s[BIT_RX_READY] = rxHas;
    s[BIT_TX_EMPTY] = txEmpty;
    s[BIT_TX_ROOM]  = txRoom;
    return s;
  endfunction

  function automatic logic chanOf(input logic selAN);
    // channel a wins if a host ever lowers both selects
    return selAN ? 1'b1 : 1'b0;
  endfunction

  // ***************************************************************
  // strobe edge detection
  // ***************************************************************
  logic prevRead;
  logic prevWrite;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevRead  <= 1'b1;
      prevWrite <= 1'b1;
    end else begin
      prevRead  <= bus.readStrobeN;
      prevWrite <= bus.writeStrobeN;
    end
  end

  wire logic anySelect = !bus.chanASelectN || !bus.chanBSelectN;
  wire logic readFall  = prevRead && !bus.readStrobeN;
  wire logic readRise  = !prevRead && bus.readStrobeN;
  wire logic writeFall = prevWrite && !bus.writeStrobeN;
  wire logic writeRise = !prevWrite && bus.writeStrobeN;

  // ***************************************************************
  // read cycle tracking
  // ***************************************************************
  logic              readActive;
  logic              readChan;
  logic [ADDR_W-1:0] readAddr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readActive <= 1'b0;
      readChan   <= 1'b0;
      readAddr   <= '0;
    end else if (readFall && anySelect) begin
      readActive <= 1'b1;
      readChan   <= chanOf(bus.chanASelectN);
      readAddr   <= bus.regAddr;
    end else if (readRise) begin
      readActive <= 1'b0;
    end
  end

  // ***************************************************************
  // write cycle tracking
  // ***************************************************************
  logic              writeActive;
  logic              writeChan;
  logic [ADDR_W-1:0] writeAddr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writeActive <= 1'b0;
      writeChan   <= 1'b0;
      writeAddr   <= '0;
    end else if (writeFall && anySelect) begin
      writeActive <= 1'b1;
      writeChan   <= chanOf(bus.chanASelectN);
      writeAddr   <= bus.regAddr;
    end else if (writeRise) begin
      writeActive <= 1'b0;
    end
  end

  wire logic writeCommit = writeRise && writeActive;
  wire logic readCommit  = readRise && readActive;

  // ***************************************************************
  // per-channel control registers
  // ***************************************************************
  logic [CHANNELS-1:0][DATA_W-1:0] lineCtrl;
  logic [CHANNELS-1:0][DATA_W-1:0] irqEnable;
  logic [CHANNELS-1:0][DATA_W-1:0] scratch;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineCtrl  <= {CHANNELS{LINE_CTRL_RESET}};
      irqEnable <= {CHANNELS{IRQ_EN_RESET}};
      scratch   <= {CHANNELS{SCRATCH_RESET}};
    end else if (writeCommit) begin
      unique case (writeAddr)
        OFF_LINE_CTRL: lineCtrl[writeChan]  <= bus.busLevel;
        OFF_IRQ_EN:    irqEnable[writeChan] <= bus.busLevel;
        OFF_SCRATCH:   scratch[writeChan]   <= bus.busLevel;
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // transmit and receive fifos
  // ***************************************************************
  logic [CHANNELS-1:0]             txPush;
  logic [CHANNELS-1:0]             txRoom;
  logic [CHANNELS-1:0]             txHas;
  logic [CHANNELS-1:0]             rxPop;
  logic [CHANNELS-1:0]             rxHas;
  logic [CHANNELS-1:0][DATA_W-1:0] rxHead;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    // a write into a full transmit fifo is dropped, as in a classic uart
    assign txPush[ch] = writeCommit && (writeChan == 1'(ch)) && (writeAddr == OFF_DATA);
    // popping at the read strobe rise keeps the byte stable while the host samples it
    assign rxPop[ch]  = readCommit && (readChan == 1'(ch)) && (readAddr == OFF_DATA);

    byte_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
    ) u_tx_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (txPush[ch]),
      .inReady  (txRoom[ch]),
      .inData   (bus.busLevel),
      .outValid (txHas[ch]),
      .outReady (txReady[ch]),
      .outData  (txData[ch])
    );

    byte_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
    ) u_rx_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (rxValid[ch]),
      .inReady  (rxReady[ch]),
      .inData   (rxData[ch]),
      .outValid (rxHas[ch]),
      .outReady (rxPop[ch]),
      .outData  (rxHead[ch])
    );
  end

  assign txValid = txHas;

  // ***************************************************************
  // read data path
  // ***************************************************************
  logic [DATA_W-1:0] readValue;
  logic [DATA_W-1:0] devData;
  logic              devDataOe;
  logic              curChan;

  always_comb begin
    curChan = chanOf(bus.chanASelectN);
    unique case (bus.regAddr)
      OFF_DATA:      readValue = rxHas[curChan] ? rxHead[curChan] : '0;
      OFF_IRQ_EN:    readValue = irqEnable[curChan];
      OFF_LINE_CTRL: readValue = lineCtrl[curChan];
      OFF_STATUS:    readValue = statusByte(rxHas[curChan], !txHas[curChan], txRoom[curChan]);
      OFF_SCRATCH:   readValue = scratch[curChan];
      default:       readValue = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      devData <= '0;
    end else if (readFall && anySelect) begin
      devData <= readValue;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      devDataOe <= 1'b0;
    end else if (readFall && anySelect) begin
      devDataOe <= 1'b1;
    end else if (readRise) begin
      devDataOe <= 1'b0;
    end
  end

  assign bus.devData   = devData;
  assign bus.devDataOe = devDataOe;

  // ***************************************************************
  // interrupt, general-purpose and ready pins
  // ***************************************************************
  logic [CHANNELS-1:0] irqLevel;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqLevel <= '0;
    end else begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        irqLevel[ch] <= (irqEnable[ch][BIT_IEN_RX] && rxHas[ch]) ||
                        (irqEnable[ch][BIT_IEN_TX] && !txHas[ch]);
      end
    end
  end

  assign bus.chanAIrq    = irqLevel[0];
  assign bus.chanBIrq    = irqLevel[1];
  assign bus.chanAIrqOe  = lineCtrl[0][BIT_IRQ_OE];
  assign bus.chanBIrqOe  = lineCtrl[1][BIT_IRQ_OE];
  assign bus.chanAGpOutN = !lineCtrl[0][BIT_IRQ_OE];
  assign bus.chanBGpOutN = !lineCtrl[1][BIT_IRQ_OE];

  // ready pins reflect fifo state directly; no trigger levels here
  assign bus.chanATxAvailN = !txRoom[0];
  assign bus.chanBTxAvailN = !txRoom[1];
  assign bus.chanARxAvailN = !rxHas[0];
  assign bus.chanBRxAvailN = !rxHas[1];

endmodule

// ### verilog/duart_host_end.sv
// host end that runs single read and write cycles on the uart bus
`timescale 1ns/100ps
module duart_host_end
  import duart_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  duart_bus_if.host              bus,
  input  wire logic              cmdValid,
  output wire logic              cmdReady,
  input  wire logic              cmdWrite,
  input  wire logic              cmdChan,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdData,
  output wire logic              rspValid,
  output wire logic [DATA_W-1:0] rspData
);

  // ***************************************************************
  // cycle sequencer
  // ***************************************************************
  host_state_e       state;
  logic [3:0]        count;
  logic              isWrite;
  logic [ADDR_W-1:0] addr;
  logic              selAN;
  logic              selBN;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W-1:0] rdData;
  logic              rdDone;

  assign cmdReady = (state == HOST_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HOST_IDLE;
      count <= '0;
    end else begin
      unique case (state)
        HOST_IDLE: begin
          if (cmdValid) begin
            state <= HOST_SETUP;
            count <= 4'(SETUP_CYCLES - 1);
          end
        end
        HOST_SETUP: begin
          if (count == '0) begin
            state <= HOST_STROBE;
            count <= 4'(STROBE_CYCLES - 1);
          end else begin
            count <= count - 1'b1;
          end
        end
        HOST_STROBE: begin
          if (count == '0) begin
            state <= HOST_HOLD;
            count <= 4'(HOLD_CYCLES - 1);
          end else begin
            count <= count - 1'b1;
          end
        end
        HOST_HOLD: begin
          if (count == '0) begin
            state <= HOST_IDLE;
          end else begin
            count <= count - 1'b1;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // address, select and write data held for the whole cycle
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isWrite <= 1'b0;
      addr    <= '0;
      selAN   <= 1'b1;
      selBN   <= 1'b1;
      wrData  <= '0;
    end else if (state == HOST_IDLE && cmdValid) begin
      isWrite <= cmdWrite;
      addr    <= cmdAddr;
      selAN   <= cmdChan;
      selBN   <= !cmdChan;
      wrData  <= cmdData;
    end else if (state == HOST_HOLD && count == '0) begin
      selAN <= 1'b1;
      selBN <= 1'b1;
    end
  end

  // ***************************************************************
  // read capture on the strobe rise
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
      rdDone <= 1'b0;
    end else begin
      rdDone <= 1'b0;
      if (state == HOST_STROBE && count == '0 && !isWrite) begin
        rdData <= bus.busLevel;
        rdDone <= 1'b1;
      end
    end
  end

  wire logic strobing = (state == HOST_STROBE);

  assign bus.regAddr      = addr;
  assign bus.chanASelectN = selAN;
  assign bus.chanBSelectN = selBN;
  assign bus.readStrobeN  = !(strobing && !isWrite);
  assign bus.writeStrobeN = !(strobing && isWrite);
  // data stays driven through hold so the device sees it at the strobe rise
  assign bus.hostData     = wrData;
  assign bus.hostDataOe   = isWrite && (strobing || state == HOST_HOLD);
  assign rspValid         = rdDone;
  assign rspData          = rdData;

endmodule

// ### verilog/duart_pkg.sv
// shared constants and types for the dual uart host bus port
package duart_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int CHANNELS   = 2;
  localparam int ADDR_W     = 3;
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 64;

  // ***************************************************************
  // per-channel register offsets
  // ***************************************************************
  localparam logic [ADDR_W-1:0] OFF_DATA      = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN    = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_LINE_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 3'h5;
  localparam logic [ADDR_W-1:0] OFF_SCRATCH   = 3'h7;

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int BIT_IRQ_OE   = 3;
  localparam int BIT_IEN_RX   = 0;
  localparam int BIT_IEN_TX   = 1;
  localparam int BIT_RX_READY = 0;
  localparam int BIT_TX_EMPTY = 5;
  localparam int BIT_TX_ROOM  = 6;

  localparam logic [DATA_W-1:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_EN_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] SCRATCH_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE_LEVEL  = 8'hFF;

  // ***************************************************************
  // host bus timing in clock cycles
  // ***************************************************************
  localparam int SETUP_CYCLES  = 1;
  localparam int STROBE_CYCLES = 4;
  localparam int HOLD_CYCLES   = 1;

  typedef enum logic [1:0] {
    HOST_IDLE   = 2'b00,
    HOST_SETUP  = 2'b01,
    HOST_STROBE = 2'b11,
    HOST_HOLD   = 2'b10
  } host_state_e;

endpackage
